//--- verilog/clkmon_pkg.sv
// Purpose: Constants for the fail-safe clock monitor
// Assumes: 32-bit APB, byte addresses, mclk 100 MHz
// Notes: Register offsets and field positions
`default_nettype none
package clkmon_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] A_CFG = 5'h00;
  localparam logic [4:0] A_OSC = 5'h04;
  localparam logic [4:0] A_FLAG = 5'h08;
  localparam logic [4:0] A_IE = 5'h0c;
  localparam logic [4:0] A_CMD = 5'h10;
  localparam logic [4:0] A_STAT = 5'h14;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CFG_EN_BIT = 6;
  localparam int PRIMARY_RUNNING_FLAG_BIT = 3;
  localparam int FLAG_BIT = 7;
  localparam int IE_BIT = 7;
  localparam int SLEEP_BIT = 0;
  localparam logic [7:0] CFG_RST = 8'h44;
  localparam logic [7:0] OSC_RST = 8'h00;
  localparam logic [7:0] OSC_WMASK = 8'hf3;
  // ****************************************
  // Modes, selects, divider
  // ****************************************
  localparam logic [2:0] MODE_EC = 3'h4;
  localparam logic [1:0] SEL_PRI = 2'h0;
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_INT = 2'h2;
  localparam int DIV_W = 6;
  localparam logic [5:0] DIV_LAST = 6'h3f;
  localparam logic [5:0] DIV_HALF = 6'h1f;
  typedef enum logic [1:0] {st_start, st_run, st_fail} mon_st_t;
endpackage : clkmon_pkg
`default_nettype wire

//--- verilog/failsafe_clock_monitor.sv
// Purpose: Fail-safe clock monitor with APB registers
// Assumes: Clock pins sampled on mclk (100 MHz)
// Notes: Divider counts filtered RC clock edges
`default_nettype none
module failsafe_clock_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pins
  input wire logic sys_clk_pin,
  input wire logic internal_rc_clock,
  // Clock system
  input wire logic primary_ready,
  input wire logic wdt_enable,
  input wire logic pm_wake_evt,
  output logic [1:0] clk_sel,
  output logic primary_enable,
  output logic rc_keep_on,
  output logic wdt_clear,
  output logic cpu_resume,
  output logic failsafe_active,
  output logic pm_active
);
  import clkmon_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] rc_s;
    logic [2:0] sy_s;
    logic rc_l;
    logic sy_l;
    logic [DIV_W-1:0] div;
    logic latch;
    mon_st_t st;
    logic pm;
    logic [7:0] cfg;
    logic [7:0] osc;
    logic flag;
    logic ie;
    logic [1:0] sel;
    logic pri_en;
    logic wclr;
    logic resume;
    logic [31:0] rdata;
    logic err;
  } state_t;

  state_t s_q;
  state_t s_d;

  localparam state_t S_RST = '{
    rc_s: 3'h0, sy_s: 3'h0, rc_l: 1'b0,
    sy_l: 1'b0, div: '0, latch: 1'b0,
    st: st_start, pm: 1'b0, cfg: CFG_RST,
    osc: OSC_RST, flag: 1'b0, ie: 1'b0,
    sel: SEL_INT, pri_en: 1'b1,
    wclr: 1'b0, resume: 1'b0,
    rdata: 32'h0, err: 1'b0};

  // ****************************************
  // Edge detection and monitor terms
  // ****************************************
  logic rc_rise;
  logic sy_fall;
  logic samp_rise;
  logic samp_fall;
  logic crystal;
  logic mon_on;
  logic fail;
  logic wr;
  logic setup;
  logic sleep_cmd;
  logic mapped;
  logic [4:0] a;

  assign a = paddr[4:0];
  // Change counts once stages two and three agree
  assign rc_rise = clk_en & (s_q.rc_s[1] == s_q.rc_s[2])
    & s_q.rc_s[2] & ~s_q.rc_l;
  assign sy_fall = clk_en & (s_q.sy_s[1] == s_q.sy_s[2])
    & ~s_q.sy_s[2] & s_q.sy_l;
  assign samp_rise = rc_rise & (s_q.div == DIV_HALF);
  assign samp_fall = rc_rise & (s_q.div == DIV_LAST);
  assign crystal = s_q.cfg[2:0] < MODE_EC;
  // Internal source is never watched
  assign mon_on = s_q.cfg[CFG_EN_BIT]
    & (s_q.st == st_run) & ~s_q.sel[1];
  assign fail = mon_on & samp_fall & s_q.latch;
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & clk_en;
  assign sleep_cmd = wr & (a == A_CMD)
    & pwdata[SLEEP_BIT];
  assign mapped = paddr[31:5] == 27'h0
    && paddr[1:0] == 2'h0 && a <= A_STAT;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rc_s = {s_q.rc_s[1:0], internal_rc_clock};
    s_d.sy_s = {s_q.sy_s[1:0], sys_clk_pin};
    if (s_q.rc_s[1] == s_q.rc_s[2]) begin
      s_d.rc_l = s_q.rc_s[2];
    end
    if (s_q.sy_s[1] == s_q.sy_s[2]) begin
      s_d.sy_l = s_q.sy_s[2];
    end
    if (rc_rise) begin
      s_d.div = s_q.div + 6'h01;
    end
    // Set wins when both edges meet
    if (sy_fall) begin
      s_d.latch = 1'b1;
    end else if (samp_rise) begin
      s_d.latch = 1'b0;
    end
    s_d.wclr = 1'b0;
    s_d.resume = 1'b0;
    if (pm_wake_evt) begin
      s_d.pm = 1'b0;
    end
    // Register writes
    if (wr) begin
      case (a)
        A_CFG: s_d.cfg = pwdata[7:0];
        A_OSC: s_d.osc = pwdata[7:0] & OSC_WMASK;
        A_FLAG: begin
          if (pwdata[FLAG_BIT]) begin
            s_d.flag = 1'b0;
          end
        end
        A_IE: s_d.ie = pwdata[IE_BIT];
        default: s_d.ie = s_q.ie;
      endcase
    end
    case (s_q.st)
      st_start: begin
        // Running on internal mux while waiting
        s_d.sel = SEL_INT;
        if (!crystal) begin
          s_d.st = st_run;
        end else if (primary_ready
            && s_q.osc[1:0] == SEL_PRI) begin
          s_d.st = st_run;
        end
        // No failure is raised while waiting
        s_d.pri_en = s_q.osc[1:0] == SEL_PRI;
      end
      st_run: begin
        s_d.sel = s_q.osc[1] ? SEL_INT : s_q.osc[1:0];
        s_d.pri_en = s_q.osc[1:0] == SEL_PRI;
        if (fail) begin
          s_d.st = st_fail;
          s_d.sel = SEL_INT;
          s_d.wclr = 1'b1;
          if (s_q.pm && s_q.ie) begin
            s_d.pm = 1'b0;
            s_d.resume = 1'b1;
          end
        end
      end
      st_fail: begin
        // Later wakes still execute on internal mux
        s_d.sel = SEL_INT;
      end
      default: s_d.st = st_start;
    endcase
    if (fail) begin
      s_d.flag = 1'b1;
    end
    // Sleep clears fail-safe; a crystal primary restarts start-up on internal, others take the written select
    if (sleep_cmd) begin
      s_d.pm = 1'b1;
      if (s_d.osc[1:0] == SEL_PRI && crystal) begin
        s_d.st = st_start;
        s_d.sel = SEL_INT;
      end else begin
        s_d.st = st_run;
        s_d.sel = s_d.osc[1] ? SEL_INT : s_d.osc[1:0];
      end
      s_d.pri_en = s_d.osc[1:0] == SEL_PRI;
      // A monitored fall in the same cycle still wins
      s_d.latch = sy_fall;
    end
    // Read data is captured in the setup cycle
    if (setup) begin
      s_d.err = !mapped;
      s_d.rdata = 32'h0;
      case (a)
        A_CFG: s_d.rdata[7:0] = s_q.cfg;
        A_OSC: begin
          s_d.rdata[7:0] = s_q.osc;
          s_d.rdata[PRIMARY_RUNNING_FLAG_BIT] = (s_q.st == st_run)
            && s_q.sel == SEL_PRI;
        end
        A_FLAG: s_d.rdata[FLAG_BIT] = s_q.flag;
        A_IE: s_d.rdata[IE_BIT] = s_q.ie;
        A_STAT: s_d.rdata[3:0] = {s_q.pm,
          s_q.st == st_fail, s_q.sel};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= S_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Zero-wait slave; clock enable low stalls it
  assign pready = psel & penable & clk_en;
  assign pslverr = pready & s_q.err;
  assign prdata = s_q.rdata;
  assign clk_sel = s_q.sel;
  assign primary_enable = s_q.pri_en;
  // Watchdog has its own enable path
  assign rc_keep_on = s_q.cfg[CFG_EN_BIT] | wdt_enable;
  assign wdt_clear = s_q.wclr;
  assign cpu_resume = s_q.resume;
  assign failsafe_active = s_q.st == st_fail;
  assign pm_active = s_q.pm;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_enable;
    !s_q.cfg[CFG_EN_BIT] |-> !fail;
  endproperty
  a_enable: assert property (p_enable)
    else $error("failure without enable");

  property p_rc_on;
    s_q.cfg[CFG_EN_BIT] && !wdt_enable |-> rc_keep_on;
  endproperty
  a_rc_on: assert property (p_rc_on)
    else $error("rc clock dropped");

  property p_div;
    rc_rise |=> s_q.div
      == $past(s_q.div, 1) + 6'h01;
  endproperty
  a_div: assert property (p_div)
    else $error("sample divider wrong");

  property p_latch;
    clk_en && sy_fall |=> s_q.latch;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch not set");

  property p_flag;
    clk_en && fail |=> s_q.flag && wdt_clear;
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag or watchdog clear missing");

  property p_switch;
    clk_en && fail |=> clk_sel == SEL_INT
      && s_q.osc == $past(s_q.osc);
  endproperty
  a_switch: assert property (p_switch)
    else $error("no switch or control changed");

  property p_internal;
    s_q.sel == SEL_INT |-> !fail;
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal source flagged");

  property p_hold;
    failsafe_active && !sleep_cmd |=> failsafe_active;
  endproperty
  a_hold: assert property (p_hold)
    else $error("fail-safe left early");

  property p_sleep;
    sleep_cmd |=> !failsafe_active && pm_active;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not clear fail-safe");

  property p_pm_stay;
    clk_en && fail && s_q.pm && !s_q.ie
      && !pm_wake_evt |=> pm_active && !cpu_resume;
  endproperty
  a_pm_stay: assert property (p_pm_stay)
    else $error("left managed mode");

  property p_start;
    s_q.st == st_start |-> !fail && clk_sel == SEL_INT;
  endproperty
  a_start: assert property (p_start)
    else $error("start-up misbehaves");

  property p_div_hold;
    clk_en && !rc_rise |=> $stable(s_q.div);
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divider moved without an edge");

  property p_clear;
    samp_rise && !sy_fall |=> !s_q.latch;
  endproperty
  a_clear: assert property (p_clear)
    else $error("latch not cleared");

  property p_detect;
    samp_fall && s_q.latch && s_q.cfg[CFG_EN_BIT] && s_q.st == st_run
      && s_q.sel != SEL_INT && !sleep_cmd |=> failsafe_active;
  endproperty
  a_detect: assert property (p_detect)
    else $error("failure missed");

  property p_flag_hold;
    s_q.flag && !(wr && a == A_FLAG && pwdata[FLAG_BIT]) |=> s_q.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag lost");

  property p_wclr_src;
    wdt_clear && $past(clk_en) |-> $past(fail);
  endproperty
  a_wclr_src: assert property (p_wclr_src)
    else $error("stray watchdog clear");

  property p_resume;
    fail && s_q.pm && s_q.ie && !sleep_cmd
      |=> cpu_resume && !pm_active && clk_sel == SEL_INT;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no resume on internal clock");

  property p_sync;
    sy_fall && $past(clk_en, 1) && $past(clk_en, 2) && $past(clk_en, 3)
      |-> !$past(sys_clk_pin, 2) && !$past(sys_clk_pin, 3);
  endproperty
  a_sync: assert property (p_sync)
    else $error("fall taken before synchroniser agreed");

  c_fail: cover property (clk_en && fail);
  c_wake: cover property (cpu_resume);
  c_exit: cover property (failsafe_active ##1 sleep_cmd);
  c_start: cover property (s_q.st == st_start ##1 s_q.st == st_run);
  c_stay: cover property (clk_en && fail && s_q.pm && !s_q.ie);
endmodule : failsafe_clock_monitor
`default_nettype wire

//--- test/osc_model.sv
// Purpose: External oscillator and RC clock model
// Assumes: Times in ns
// Notes: Slow start by withholding ready
`default_nettype none
module osc_model (
  // Control
  input wire logic primary_enable,
  input wire logic run,
  input wire logic hold,
  // Clocks
  output logic sys_clk_pin,
  output logic internal_rc_clock,
  output logic primary_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sys_clk_pin = 1'h0;
    internal_rc_clock = 1'h0;
    // RC source never stops; offset keeps its edges off mclk edges
    #2;
    forever #45 internal_rc_clock = ~internal_rc_clock;
  end
  // Stopped oscillator makes no edges at all; pin holds its last level
  always begin
    #50;
    if (run) begin
      sys_clk_pin = ~sys_clk_pin;
    end
  end
  assign primary_ready = primary_enable & ~hold;
endmodule : osc_model
`default_nettype wire

//--- test/testbench.sv
// Purpose: Self-checking bench for the clock monitor
// Assumes: APB zero wait, mclk 100 MHz
// Notes: Read results checked by a queue monitor
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import clkmon_pkg::*;
  typedef struct packed {logic [7:0] e; logic [7:0] m; logic x;} note_t;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, run = 1'h0, hold = 1'h0;
  logic wdt_enable = 1'h0, pm_wake_evt = 1'h0, clk_en = 1'h1;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic pready, pslverr, sys_clk_pin, internal_rc_clock, primary_ready, primary_enable;
  logic rc_keep_on, wdt_clear, cpu_resume, failsafe_active, pm_active;
  logic [1:0] clk_sel;
  int seed = 32'h1cf0, err_total = 0, num_checks = 0;
  note_t q[$];
  always #5 mclk = ~mclk;
  failsafe_clock_monitor dut (.mclk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sys_clk_pin, .internal_rc_clock, .primary_ready,
    .wdt_enable, .pm_wake_evt, .clk_sel, .primary_enable, .rc_keep_on, .wdt_clear,
    .cpu_resume, .failsafe_active, .pm_active);
  osc_model ext (.primary_enable, .run, .hold, .sys_clk_pin, .internal_rc_clock, .primary_ready);
  // ****************************************
  // Tasks
  // ****************************************
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Request held until pready is seen at an edge
  task apb(input logic w, input logic [4:0] a, input logic [7:0] d, input note_t nt);
    r = $random(seed);
    if (!w) q.push_back(nt);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {27'h0, a};
    pwdata <= {r[31:8], d};
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff, input logic x = 1'h0);
    apb(1'h0, a, 8'h0, '{e, m, x});
  endtask : rd
  task wr(input logic [4:0] a, input logic [7:0] d);
    apb(1'h1, a, d, '{8'h0, 8'h0, 1'h0});
  endtask : wr
  // Bounded wait: a sample period is about 580 cycles
  task wait_fs;
    int i;
    i = 0;
    while (failsafe_active !== 1'h1 && i < 3000) begin
      @(posedge mclk);
      i++;
    end
    check("failsafe_active", failsafe_active, 1'h1);
  endtask : wait_fs
  // ****************************************
  // Monitor
  // ****************************************
  always @(posedge mclk) begin
    if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1 && pwrite === 1'h0 && q.size() > 0) begin
      check("prdata", prdata & {24'h0, q[0].m}, {24'h0, q[0].e & q[0].m});
      check("pslverr", pslverr, q[0].x);
      void'(q.pop_front());
    end
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    cyc(3);
    reset <= 1'h0;
    cyc(5);
    rd(A_CFG, CFG_RST);
    rd(A_OSC, 8'h08);
    rd(A_STAT, 8'h00);
    rd(5'h18, 8'h00, 8'hff, 1'h1);
    check("rc_keep_on", rc_keep_on, 1'h1);
    wr(A_CFG, 8'h04);
    wdt_enable <= 1'h1;
    run <= 1'h1;
    cyc(1500);
    check("rc_keep_on", rc_keep_on, 1'h1);
    check("failsafe_active", failsafe_active, 1'h0);
    rd(A_FLAG, 8'h00);
    wr(A_CFG, CFG_RST);
    wdt_enable <= 1'h0;
    wait_fs();
    check("clk_sel", clk_sel, SEL_INT);
    check("wdt_clear", wdt_clear, 1'h1);
    cyc(1);
    check("wdt_clear", wdt_clear, 1'h0);
    check("rc_keep_on", rc_keep_on, 1'h1);
    rd(A_FLAG, 8'h80);
    rd(A_OSC, 8'h00, OSC_WMASK);
    wr(A_FLAG, 8'h80);
    cyc(1200);
    rd(A_FLAG, 8'h00);
    rd(A_STAT, 8'h06);
    run <= 1'h0;
    wr(A_OSC, 8'h01);
    wr(A_CMD, 8'h01);
    rd(A_STAT, 8'h09);
    check("primary_enable", primary_enable, 1'h0);
    run <= 1'h1;
    wait_fs();
    check("pm_active", pm_active, 1'h1);
    check("cpu_resume", cpu_resume, 1'h0);
    rd(A_STAT, 8'h0e);
    pm_wake_evt <= 1'h1;
    cyc(1);
    pm_wake_evt <= 1'h0;
    rd(A_STAT, 8'h06);
    run <= 1'h0;
    wr(A_IE, 8'h80);
    wr(A_CMD, 8'h01);
    rd(A_STAT, 8'h09);
    run <= 1'h1;
    wait_fs();
    check("cpu_resume", cpu_resume, 1'h1);
    check("pm_active", pm_active, 1'h0);
    // Reset in mid-run while fail-safe holds
    reset <= 1'h1;
    run <= 1'h0;
    cyc(3);
    check("failsafe_active", failsafe_active, 1'h0);
    reset <= 1'h0;
    cyc(5);
    wr(A_CFG, 8'h42);
    wr(A_OSC, 8'h00);
    hold <= 1'h1;
    wr(A_CMD, 8'h01);
    cyc(2);
    check("clk_sel", clk_sel, SEL_INT);
    check("primary_enable", primary_enable, 1'h1);
    rd(A_OSC, 8'h00, 8'h08);
    run <= 1'h1;
    cyc(1200);
    check("failsafe_active", failsafe_active, 1'h0);
    run <= 1'h0;
    // A sample rise must clear the latch before monitoring resumes
    cyc(700);
    hold <= 1'h0;
    cyc(20);
    check("clk_sel", clk_sel, SEL_PRI);
    rd(A_OSC, 8'h08, 8'h08);
    // Clock enable low freezes every register
    clk_en <= 1'h0;
    pm_wake_evt <= 1'h1;
    cyc(3);
    check("pm_active", pm_active, 1'h1);
    clk_en <= 1'h1;
    pm_wake_evt <= 1'h0;
    rd(A_STAT, 8'h08);
    end_of_test();
  end
  // Whole run needs about 6k cycles
  initial begin
    #900000;
    err_total++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
